// ===== dv/bbt_cfg_master.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Configuration master on the primary bus
// ------------------------------------------------------------
module bbt_cfg_master
(
  input  wire logic        clk,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_dword_addr,
  output logic [3:0]       upstream_cmd_byte_en_n,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_dword_addr = 8'h00;
    upstream_cmd_byte_en_n = 4'hF;
    cfg_wdata = 32'h0;
  end

  // Released lines show the inverse, so stale values never pass for live ones
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_dword_addr <= a;
    upstream_cmd_byte_en_n <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_dword_addr <= ~a;
    upstream_cmd_byte_en_n <= ~be;
    cfg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_dword_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_dword_addr <= ~a;
    @(negedge clk);
    d = cfg_rdata;
  endtask
endmodule

// ===== dv/bbt_config_bank_tb.sv
`timescale 1ns/1ns

module bbt_config_bank_tb;
  import bbt_pkg::*;
  typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} bbt_row_t;
  // ------------------------------------------------------------
  // Register rows: address, byte enables, write data, readback
  // ------------------------------------------------------------
  localparam bbt_row_t ROWS [7] = '{
    '{8'h0C, 4'h0, 32'hFFFFFFFF, 32'h0001FF00},
    '{8'h0C, 4'hD, 32'h00000300, 32'h00010300},
    '{8'h18, 4'h0, 32'h11080402, 32'h11080402},
    '{8'h18, 4'h7, 32'h05FFFFFF, 32'h05080402},
    '{8'h1C, 4'h0, 32'hFFFFFFFF, 32'h000000F1},
    '{8'h1C, 4'hE, 32'h00000032, 32'h00000031},
    '{8'h40, 4'h0, 32'hFFFFFFFF, 32'h00000000}};
  logic        clk, rst_n, cwr, crd;
  logic [7:0]  cad, pb, sb;
  logic [3:0]  cbe, iln;
  logic [31:0] cwd, crdata, rv, ia;
  logic        fs, mst, gnt, mwi, dx, bnd, ps, ss;
  logic        pv, pc, pl, pp, sv, sp, tsp, tup, iv, fw;
  logic [15:0] ibu, ilu;
  int          errors, checked;

  bbt_cfg_master u_master (.clk(clk), .cfg_wr(cwr), .cfg_rd(crd), .cfg_dword_addr(cad),
    .upstream_cmd_byte_en_n(cbe), .cfg_wdata(cwd), .cfg_rdata(crdata));

  // Both buses share one set of master stimulus so their limits are compared side by side
  bbt_config_bank dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cwr), .cfg_rd(crd),
    .cfg_dword_addr(cad), .upstream_cmd_byte_en_n(cbe), .cfg_wdata(cwd), .cfg_rdata(crdata),
    .pri_frame_start(fs), .pri_mastering(mst), .pri_grant(gnt), .pri_mwi(mwi),
    .pri_data_xfer(dx), .pri_line_boundary(bnd), .pri_stop_burst(ps),
    .sec_frame_start(fs), .sec_mastering(mst), .sec_grant(gnt), .sec_mwi(mwi),
    .sec_data_xfer(dx), .sec_line_boundary(bnd), .sec_stop_burst(ss),
    .pri_t1_valid(pv), .pri_t1_bus(pb), .pri_t1_claim(pc), .pri_t1_to_local(pl),
    .pri_t1_pass_on(pp), .sec_t1_valid(sv), .sec_t1_bus(sb), .sec_t1_special_req(sp),
    .sec_t1_to_special(tsp), .sec_t1_upstream(tup), .io_base_upper(ibu),
    .io_limit_nibble(iln), .io_limit_upper(ilu), .io_req_valid(iv), .io_req_addr(ia),
    .io_forward(fw));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Grant is dropped one edge late so a stale expired count cannot stop the new frame
  task automatic burst(input logic w, input logic b, input logic x, input int ep, input int es);
    @(posedge clk);
    fs <= 1'b1;
    mst <= 1'b1;
    mwi <= w;
    bnd <= b;
    for (int k = 1; k <= 8; k++)
    begin
      @(posedge clk);
      fs <= 1'b0;
      gnt <= 1'b0;
      dx <= (k == 1);
      @(negedge clk);
      chk("pri_stop", {31'h0, ps}, {31'h0, x && k >= ep});
      chk("sec_stop", {31'h0, ss}, {31'h0, x && k >= es});
    end
    @(posedge clk);
    mst <= 1'b0;
    gnt <= 1'b1;
  endtask

  task automatic t1(input logic [7:0] p, input logic [7:0] s, input logic q, input logic [4:0] e);
    @(posedge clk);
    pv <= 1'b1;
    sv <= 1'b1;
    pb <= p;
    sb <= s;
    sp <= q;
    @(posedge clk);
    pv <= 1'b0;
    sv <= 1'b0;
    pb <= ~p;
    sb <= ~s;
    @(negedge clk);
    chk("type1", {27'h0, pc, pl, pp, tsp, tup}, {27'h0, e});
  endtask

  task automatic io(input logic [31:0] a, input logic e);
    @(posedge clk);
    iv <= 1'b1;
    ia <= a;
    @(posedge clk);
    iv <= 1'b0;
    ia <= ~a;
    @(negedge clk);
    chk("io_forward", {31'h0, fw}, {31'h0, e});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {clk, rst_n, fs, mst, mwi, dx, bnd, pv, sv, sp, iv} = '0;
    {pb, sb, ia, errors, checked} = '0;
    gnt = 1'b1;
    ibu = 16'h0001;
    ilu = 16'h0001;
    iln = 4'h5;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      u_master.wr(ROWS[i].a, ROWS[i].be, ROWS[i].d);
      u_master.rd(ROWS[i].a, rv);
      chk("cfg_rdata", rv, ROWS[i].e);
    end
    // Limits are now 3 and 5: expiry shows one edge after the count reaches zero
    burst(1'b0, 1'b0, 1'b1, 5, 7);
    burst(1'b1, 1'b0, 1'b0, 5, 7);
    burst(1'b1, 1'b1, 1'b1, 5, 7);
    t1(8'h04, 8'h02, 1'b1, 5'b11010);
    t1(8'h06, 8'h02, 1'b0, 5'b10101);
    t1(8'h08, 8'h05, 1'b0, 5'b10100);
    t1(8'h09, 8'h09, 1'b1, 5'b00001);
    t1(8'h03, 8'h04, 1'b0, 5'b00000);
    io(32'h00012FFF, 1'b0);
    io(32'h00013000, 1'b1);
    io(32'h00015FFF, 1'b1);
    io(32'h00016000, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    u_master.rd(BBT_OFS_TIMER_HDR, rv);
    chk("rst_0c", rv, {8'h00, BBT_HDR_CODE, 16'h0000});
    u_master.rd(BBT_OFS_BUS_NUMS, rv);
    chk("rst_18", rv, 32'h00000000);
    u_master.rd(BBT_OFS_IO_WINDOW, rv);
    chk("rst_1c", rv, {28'h0, BBT_IO32_IND});
    burst(1'b0, 1'b0, 1'b1, 3, 3);
    finish_test();
  end

  initial
  begin
    #200000;
    errors++;
    finish_test();
  end
endmodule

// ===== verilog/bbt_config_bank.sv
`timescale 1ns/1ns

// Functional notes
// [RULE_01] The primary burst timer loads its limit at our primary frame start and counts clocks.
// [RULE_02] With a zero primary limit and the grant removed we leave after the first data transfer, except MWI.
// [RULE_03] An expired timer with the grant removed ends the burst at the next data phase, MWI at a line boundary.
// [RULE_04] The secondary burst timer loads its own limit at our secondary frame start and counts clocks.
// [RULE_05] With a zero secondary limit and the grant removed we end after the first transfer, except MWI.
// [RULE_06] Bits 23:16 of dword 0x0C read a fixed layout code of 0x01.
// [RULE_07] Secondary Type 1 requests to the upstream bus become special cycles, others outside go upstream.
// [RULE_08] Primary Type 1 requests to the downstream bus are claimed and turned into Type 0 or special cycles.
// [RULE_09] Primary Type 1 requests above downstream and up to the highest bus are claimed and passed as Type 1.
// [RULE_10] The low nibble of the I/O window bottom byte reads 0x1 for 32-bit I/O decode.
// [RULE_11] Bits 7:4 hold address bits 15:12 of the window bottom, low 12 bits zero, upper 16 from outside.
// [RULE_12] The limit nibble gives address bits 15:12 of the window top at 4 kB granularity.
// [RULE_13] I/O addresses from bottom to top inclusive are forwarded, with the top's low 12 bits all ones.
module bbt_config_bank
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_dword_addr,
  input  wire logic [3:0]  upstream_cmd_byte_en_n,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        pri_frame_start,
  input  wire logic        pri_mastering,
  input  wire logic        pri_grant,
  input  wire logic        pri_mwi,
  input  wire logic        pri_data_xfer,
  input  wire logic        pri_line_boundary,
  output logic             pri_stop_burst,
  input  wire logic        sec_frame_start,
  input  wire logic        sec_mastering,
  input  wire logic        sec_grant,
  input  wire logic        sec_mwi,
  input  wire logic        sec_data_xfer,
  input  wire logic        sec_line_boundary,
  output logic             sec_stop_burst,
  input  wire logic        pri_t1_valid,
  input  wire logic [7:0]  pri_t1_bus,
  output logic             pri_t1_claim,
  output logic             pri_t1_to_local,
  output logic             pri_t1_pass_on,
  input  wire logic        sec_t1_valid,
  input  wire logic [7:0]  sec_t1_bus,
  input  wire logic        sec_t1_special_req,
  output logic             sec_t1_to_special,
  output logic             sec_t1_upstream,
  input  wire logic [15:0] io_base_upper,
  input  wire logic [3:0]  io_limit_nibble,
  input  wire logic [15:0] io_limit_upper,
  input  wire logic        io_req_valid,
  input  wire logic [31:0] io_req_addr,
  output logic             io_forward
);
  import bbt_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  pri_limit;
    logic [7:0]  sec_limit;
    logic [7:0]  up_bus;
    logic [7:0]  down_bus;
    logic [7:0]  sub_bus;
    logic [3:0]  io_base;
    logic [7:0]  pri_count;
    logic [7:0]  sec_count;
    logic        pri_first;
    logic        sec_first;
    logic        pri_stop;
    logic        sec_stop;
    logic        p_claim;
    logic        p_local;
    logic        p_pass;
    logic        s_special;
    logic        s_up;
    logic        io_fwd;
    logic [31:0] rdata;
  } bbt_state_t;

  bbt_state_t state;
  bbt_state_t next_state;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] f_byte_wr(input logic [7:0] cur, input logic [31:0] wd,
                                           input logic [3:0] be_n, input int lane);
    f_byte_wr = be_n[lane] ? cur : wd[lane*8 +: 8];
  endfunction

  // Count down from the limit; zero means expired and stays there
  function automatic logic [7:0] f_count(input logic [7:0] cnt, input logic [7:0] limit,
                                         input logic start, input logic active);
    if (start)
      f_count = limit;
    else if (active && cnt != 8'h00)
      f_count = cnt - 8'h01;
    else
      f_count = cnt;
  endfunction

  // Grant gone and time up: leave once a transfer is done; MWI waits for the line end
  function automatic logic f_stop(input logic active, input logic grant, input logic [7:0] cnt,
                                  input logic first, input logic mwi, input logic boundary);
    f_stop = active && !grant && cnt == 8'h00 && first && (!mwi || boundary);
  endfunction

  logic [31:0] io_bottom;
  logic [31:0] io_top;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    io_bottom = {io_base_upper, state.io_base, BBT_IO_LOW_ZERO}; // [RULE_11]
    io_top = {io_limit_upper, io_limit_nibble, BBT_IO_LOW_ONES}; // [RULE_12] [RULE_13]

    if (cfg_wr)
    begin
      unique case (cfg_dword_addr)
        BBT_OFS_TIMER_HDR:
        begin
          next_state.pri_limit = f_byte_wr(state.pri_limit, cfg_wdata,
                                           upstream_cmd_byte_en_n, 1); // [RULE_01]
        end
        BBT_OFS_BUS_NUMS:
        begin
          next_state.up_bus = f_byte_wr(state.up_bus, cfg_wdata, upstream_cmd_byte_en_n, 0);
          next_state.down_bus = f_byte_wr(state.down_bus, cfg_wdata, upstream_cmd_byte_en_n, 1);
          next_state.sub_bus = f_byte_wr(state.sub_bus, cfg_wdata, upstream_cmd_byte_en_n, 2);
          next_state.sec_limit = f_byte_wr(state.sec_limit, cfg_wdata,
                                           upstream_cmd_byte_en_n, 3); // [RULE_04]
        end
        BBT_OFS_IO_WINDOW:
        begin
          if (!upstream_cmd_byte_en_n[0])
            next_state.io_base = cfg_wdata[BBT_POS_IO_BASE +: 4]; // [RULE_11]
        end
        default:
        begin
        end
      endcase
    end

    // Reads return the whole dword; fields owned elsewhere read as zero here
    if (cfg_rd)
    begin
      next_state.rdata = 32'h0000_0000;
      unique case (cfg_dword_addr)
        BBT_OFS_TIMER_HDR:
        begin
          next_state.rdata[BBT_POS_PRI_TIMER +: 8] = state.pri_limit;
          next_state.rdata[BBT_POS_HDR_CODE +: 8] = BBT_HDR_CODE; // [RULE_06]
        end
        BBT_OFS_BUS_NUMS:
        begin
          next_state.rdata[BBT_POS_UP_BUS +: 8] = state.up_bus;
          next_state.rdata[BBT_POS_DOWN_BUS +: 8] = state.down_bus;
          next_state.rdata[BBT_POS_SUB_BUS +: 8] = state.sub_bus;
          next_state.rdata[BBT_POS_SEC_TIMER +: 8] = state.sec_limit;
        end
        BBT_OFS_IO_WINDOW:
        begin
          next_state.rdata[BBT_POS_IO_IND +: 4] = BBT_IO32_IND; // [RULE_10]
          next_state.rdata[BBT_POS_IO_BASE +: 4] = state.io_base;
        end
        default:
        begin
        end
      endcase
    end

    // Burst timers
    next_state.pri_count = f_count(state.pri_count, state.pri_limit,
                                   pri_frame_start, pri_mastering); // [RULE_01]
    next_state.sec_count = f_count(state.sec_count, state.sec_limit,
                                   sec_frame_start, sec_mastering); // [RULE_04]
    // A transfer landing on the frame-start cycle still counts: the set wins over the clear
    if (pri_data_xfer)
      next_state.pri_first = 1'b1;
    else if (pri_frame_start)
      next_state.pri_first = 1'b0;
    if (sec_data_xfer)
      next_state.sec_first = 1'b1;
    else if (sec_frame_start)
      next_state.sec_first = 1'b0;
    next_state.pri_stop = f_stop(pri_mastering, pri_grant, state.pri_count, state.pri_first,
                                 pri_mwi, pri_line_boundary); // [RULE_02] [RULE_03]
    next_state.sec_stop = f_stop(sec_mastering, sec_grant, state.sec_count, state.sec_first,
                                 sec_mwi, sec_line_boundary); // [RULE_05] [RULE_03]

    // Primary-side Type 1 decode
    next_state.p_claim = 1'b0;
    next_state.p_local = 1'b0;
    next_state.p_pass = 1'b0;
    if (pri_t1_valid)
    begin
      if (pri_t1_bus == state.down_bus)
      begin
        next_state.p_claim = 1'b1; // [RULE_08]
        next_state.p_local = 1'b1;
      end
      else if (pri_t1_bus > state.down_bus && pri_t1_bus <= state.sub_bus)
      begin
        next_state.p_claim = 1'b1; // [RULE_09]
        next_state.p_pass = 1'b1;
      end
    end

    // Secondary-side Type 1 decode: buses behind us stay local
    next_state.s_special = 1'b0;
    next_state.s_up = 1'b0;
    if (sec_t1_valid)
    begin
      if (sec_t1_bus == state.up_bus && sec_t1_special_req)
        next_state.s_special = 1'b1; // [RULE_07]
      else if (sec_t1_bus < state.down_bus || sec_t1_bus > state.sub_bus)
        next_state.s_up = 1'b1; // [RULE_07]
    end

    next_state.io_fwd = io_req_valid && io_req_addr >= io_bottom
                        && io_req_addr <= io_top; // [RULE_13]
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.pri_limit <= BBT_RST_TIMER;
      state.sec_limit <= BBT_RST_TIMER;
      state.up_bus <= BBT_RST_BUS;
      state.down_bus <= BBT_RST_BUS;
      state.sub_bus <= BBT_RST_BUS;
      state.io_base <= BBT_RST_IO_BASE;
    end
    else
      state <= next_state;
  end

  assign cfg_rdata = state.rdata;
  assign pri_stop_burst = state.pri_stop;
  assign sec_stop_burst = state.sec_stop;
  assign pri_t1_claim = state.p_claim;
  assign pri_t1_to_local = state.p_local;
  assign pri_t1_pass_on = state.p_pass;
  assign sec_t1_to_special = state.s_special;
  assign sec_t1_upstream = state.s_up;
  assign io_forward = state.io_fwd;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pri_load_a: assert property (pri_frame_start |=> state.pri_count == $past(state.pri_limit)
                               ##1 (!$past(pri_mastering) || $past(pri_frame_start)
                               || $past(state.pri_count) == 8'h00
                               || state.pri_count == $past(state.pri_count) - 8'h01)) // [RULE_01]
    else $error("primary timer did not load or count");
  sec_load_a: assert property (sec_frame_start |=> state.sec_count == $past(state.sec_limit)) // [RULE_04]
    else $error("secondary timer did not load");
  pri_zero_a: assert property (pri_mastering && !pri_grant && !pri_mwi && state.pri_first
                               && state.pri_limit == 8'h00 && state.pri_count == 8'h00
                               |=> pri_stop_burst) // [RULE_02]
    else $error("zero primary limit did not stop burst");
  mwi_hold_a: assert property (pri_mwi && !pri_line_boundary |=> !pri_stop_burst) // [RULE_03]
    else $error("MWI stopped off a line boundary");
  sec_stop_a: assert property (sec_stop_burst |-> $past(!sec_grant && state.sec_count == 8'h00
                               && state.sec_first)) // [RULE_05]
    else $error("secondary stop without cause");
  hdr_code_a: assert property (cfg_rd && cfg_dword_addr == BBT_OFS_TIMER_HDR
                               |=> cfg_rdata[23:16] == BBT_HDR_CODE) // [RULE_06]
    else $error("layout code wrong");
  io_ind_a: assert property (cfg_rd && cfg_dword_addr == BBT_OFS_IO_WINDOW
                             |=> cfg_rdata[3:0] == BBT_IO32_IND) // [RULE_10]
    else $error("I/O decode nibble wrong");
  io_base_a: assert property (cfg_wr && cfg_dword_addr == BBT_OFS_IO_WINDOW
                              && !upstream_cmd_byte_en_n[0]
                              |=> state.io_base == $past(cfg_wdata[7:4])) // [RULE_11]
    else $error("window bottom not written");
  local_a: assert property (pri_t1_valid && pri_t1_bus == state.down_bus
                            |=> pri_t1_claim && pri_t1_to_local && !pri_t1_pass_on) // [RULE_08]
    else $error("downstream bus not claimed");
  pass_a: assert property (pri_t1_valid && pri_t1_bus > state.down_bus
                           && pri_t1_bus <= state.sub_bus |=> pri_t1_pass_on) // [RULE_09]
    else $error("subordinate bus not passed");
  up_a: assert property (sec_t1_valid && sec_t1_bus == state.up_bus && sec_t1_special_req
                         |=> sec_t1_to_special && !sec_t1_upstream) // [RULE_07]
    else $error("special cycle conversion missed");
  io_top_a: assert property (io_req_valid && io_req_addr == {io_limit_upper, io_limit_nibble,
                             12'hFFF} && io_bottom <= io_req_addr |=> io_forward) // [RULE_12] [RULE_13]
    else $error("window top not inclusive");

  pri_stop_c: cover property (pri_frame_start ##[1:20] pri_stop_burst);
  pass_c: cover property (pri_t1_pass_on);
  io_c: cover property (io_forward);
  special_c: cover property (sec_t1_to_special);
endmodule

// ===== verilog/bbt_pkg.sv
package bbt_pkg;
  // ------------------------------------------------------------
  // Dword addresses of the configuration bank
  // ------------------------------------------------------------
  localparam logic [7:0] BBT_OFS_TIMER_HDR = 8'h0C;
  localparam logic [7:0] BBT_OFS_BUS_NUMS  = 8'h18;
  localparam logic [7:0] BBT_OFS_IO_WINDOW = 8'h1C;

  // ------------------------------------------------------------
  // Field positions (low bit of each byte or nibble field)
  // ------------------------------------------------------------
  localparam int BBT_POS_PRI_TIMER  = 8;
  localparam int BBT_POS_HDR_CODE   = 16;
  localparam int BBT_POS_UP_BUS     = 0;
  localparam int BBT_POS_DOWN_BUS   = 8;
  localparam int BBT_POS_SUB_BUS    = 16;
  localparam int BBT_POS_SEC_TIMER  = 24;
  localparam int BBT_POS_IO_IND     = 0;
  localparam int BBT_POS_IO_BASE    = 4;

  // ------------------------------------------------------------
  // Fixed codes and values after reset
  // ------------------------------------------------------------
  localparam logic [7:0] BBT_HDR_CODE      = 8'h01;
  localparam logic [3:0] BBT_IO32_IND      = 4'h1;
  localparam logic [7:0] BBT_RST_TIMER     = 8'h00;
  localparam logic [7:0] BBT_RST_BUS       = 8'h00;
  localparam logic [3:0] BBT_RST_IO_BASE   = 4'h0;
  localparam logic [11:0] BBT_IO_LOW_ZERO  = 12'h000;
  localparam logic [11:0] BBT_IO_LOW_ONES  = 12'hFFF;
endpackage
